// [logic/fbac_pkg.sv]
// constants and state codes for the frame buffer address controller
package fbac_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  // search window sits seven block columns right of the reference block
  localparam logic [17:0] SW_COL_OFS   = 18'h00038;
  // one line of blocks in one field: twelve 512-byte rows
  localparam logic [17:0] LINE_BLK_OFS = 18'h01800;
  // one field of a frame; the new frame is written straight after it
  localparam logic [17:0] FIELD_FRAME  = 18'h32a00;
  // delay line length for the upper band, one line of blocks in bytes
  localparam logic [12:0] DLY_LEN      = 13'h1680;
  localparam logic [8:0]  ROW_LAST_COL = 9'h1ff;
  localparam logic [5:0]  BLK_LAST     = 6'h3f;
  localparam int          REFRESH_ROWS = 512;
  localparam int          FIFO_DEPTH   = 64;
  localparam int          MAX_XFER     = 3;
  localparam int          MV_DELAY_CYC = 36;
  // timing
  localparam int CLK_NS    = 10;
  localparam int T_PAGE_NS = 70;
  localparam int T_RAND_NS = 210;
  localparam int T_SER_NS  = 35;
  localparam int PAGE_CYC  = (T_PAGE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAND_CYC  = (T_RAND_NS + CLK_NS - 1) / CLK_NS;
  localparam int SER_CYC   = (T_SER_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_PAGE    = 3'b001,
    ST_FAST    = 3'b010,
    ST_XWAIT   = 3'b011,
    ST_XFER    = 3'b100,
    ST_REFRESH = 3'b101
  } fbac_state_e;
endpackage

// [logic/fbac_ctrl.sv]
// frame buffer address controller: search window, prediction read, transfers, refresh
`timescale 1ns/1ps
// Contract
// - one line of blocks: odd field to middle band, even field to lower band
// - next line of blocks swaps: odd to lower band, even to middle band
// - upper band comes from a delay line fed with middle band samples
// - even field search read starts at reference address plus 56
// - odd field search read starts at n+56 or n+line+56 by band position
// - serial addresses advance by increment; fields equal modulo one line
// - predicted start address taken from vector 36 cycles after block end
// - random address increments from start; even or odd data selected
// - each reconstructed block write needs one buffer-to-array transfer
// - each search window block needs one or two array-to-buffer transfers
// - each transfer takes two random cycles: wait, then row transfer
// - up to three transfers inside a prediction read, page reselected after each
// - at most two page selections per RAM per predicted block; here one at the start, then one after each transfer or row crossing
// - beyond at most 8 lost accesses, remaining samples read in fast page
// - serial port runs faster than twice the sample rate
// - one refresh on all RAMs after each predicted block read
// - 64-byte FIFO adapts memory rate to fixed coder rate
// - block start sync exchanged with the coder
// - reconstructed block kept within one memory row
// - new frame written right after the current one in spare field space
// - 70ns page cycle, 210ns random cycle, 35ns serial clock; the serial clock here runs at a 40ns period
// - addresses keep incrementing and wrap over the whole memory
module fbac_ctrl (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // coder side block timing
  input  wire logic        ref_blk_start,
  input  wire logic        ref_blk_end,
  input  wire logic        line_start,
  input  wire logic [17:0] ref_addr,
  input  wire logic        band_low,
  // motion vector as start address and even-field row count
  input  wire logic [17:0] mv_addr,
  input  wire logic [2:0]  mv_rows,
  // serial port data from the two fields
  input  wire logic [7:0]  even_sdata,
  input  wire logic [7:0]  odd_sdata,
  // random port data from the two fields
  input  wire logic [7:0]  even_rdata,
  input  wire logic [7:0]  odd_rdata,
  // delay line memory
  input  wire logic [7:0]  dly_rdata,
  output logic      [12:0] dly_addr_reg,
  output logic      [7:0]  dly_wdata_reg,
  output logic             dly_we,
  // search window to the estimator
  output logic      [7:0]  sw_mid_reg,
  output logic      [7:0]  sw_low_reg,
  output logic      [7:0]  sw_up_reg,
  output logic             mux_swap_reg,
  // serial port control
  output logic             ser_clk,
  output logic      [17:0] ser_rd_even_reg,
  output logic      [17:0] ser_rd_odd_reg,
  output logic      [17:0] ser_wr_reg,
  // random port control
  output logic      [17:0] ram_addr_reg,
  output logic             ras_n,
  output logic             cas_n,
  output logic             xfer_n,
  output logic             xfer_wr,
  output logic             refresh_n,
  output logic      [8:0]  refresh_row_reg,
  output logic             field_sel_reg,
  // predicted samples to the coder
  input  wire logic        pred_ready,
  output logic      [7:0]  pred_data,
  output logic             pred_valid,
  output logic             blk_sync_out_reg
);

  ////////////////////////////////////////////////////////////////////////////
  // serial clock and search window
  logic [1:0]  ser_cnt_reg;
  logic [6:0]  ser_left_reg;
  wire         ser_tick = (ser_cnt_reg == 2'(fbac_pkg::SER_CYC - 1));
  wire         ser_act  = (ser_left_reg != 7'h00);
  wire         ser_step = ser_tick && ser_act;
  wire  [7:0]  mid_sel  = mux_swap_reg ? even_sdata : odd_sdata;
  wire  [7:0]  low_sel  = mux_swap_reg ? odd_sdata : even_sdata;
  wire  [17:0] odd_base = band_low ? (ref_addr + fbac_pkg::LINE_BLK_OFS) : ref_addr;
  wire         rd_cross = ser_step && (ser_rd_even_reg[8:0] == fbac_pkg::ROW_LAST_COL);
  assign ser_clk = ser_act && (ser_cnt_reg < 2'(fbac_pkg::SER_CYC / 2));
  assign dly_we  = ser_step;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ser_cnt_reg     <= 2'h0;
      ser_left_reg    <= 7'h00;
      mux_swap_reg    <= 1'b0;
      ser_rd_even_reg <= 18'h00000;
      ser_rd_odd_reg  <= 18'h00000;
      ser_wr_reg      <= fbac_pkg::FIELD_FRAME;
      sw_mid_reg      <= 8'h00;
      sw_low_reg      <= 8'h00;
      sw_up_reg       <= 8'h00;
      dly_addr_reg    <= fbac_pkg::DLY_LEN - 13'h0001;
      dly_wdata_reg   <= 8'h00;
    end else begin
      ser_cnt_reg <= ser_tick ? 2'h0 : ser_cnt_reg + 2'h1;
      if (line_start) begin
        mux_swap_reg <= !mux_swap_reg;
      end
      if (ref_blk_start) begin
        ser_left_reg    <= 7'h40;
        ser_rd_even_reg <= ref_addr + fbac_pkg::SW_COL_OFS;
        ser_rd_odd_reg  <= odd_base + fbac_pkg::SW_COL_OFS;
      end else if (ser_step) begin
        ser_left_reg    <= ser_left_reg - 7'h01;
        ser_rd_even_reg <= ser_rd_even_reg + 18'h00001;
        ser_rd_odd_reg  <= ser_rd_odd_reg + 18'h00001;
        ser_wr_reg      <= ser_wr_reg + 18'h00001;
      end
      if (ser_step) begin
        sw_mid_reg    <= mid_sel;
        sw_low_reg    <= low_sel;
        sw_up_reg     <= dly_rdata;
        dly_wdata_reg <= mid_sel;
        dly_addr_reg  <= (dly_addr_reg == 13'h0000) ? fbac_pkg::DLY_LEN - 13'h0001 : dly_addr_reg - 13'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer bookkeeping
  logic [1:0] xfer_pend_reg;
  logic       xfer_wr_reg;
  logic [5:0] mv_cnt_reg;
  logic       mv_run_reg;
  logic       pred_pend_reg;
  fbac_pkg::fbac_state_e state_reg;
  fbac_pkg::fbac_state_e state_next;
  logic [4:0] rcyc_reg;
  wire        rcyc_rand = (rcyc_reg == 5'(fbac_pkg::RAND_CYC - 1));
  wire        rcyc_page = (rcyc_reg == 5'(fbac_pkg::PAGE_CYC - 1));
  wire        xfer_done = (state_reg == fbac_pkg::ST_XFER) && rcyc_rand;
  wire  [2:0] xfer_add  = (ref_blk_start ? 3'h2 : 3'h0) + (rd_cross ? 3'h1 : 3'h0);
  wire  [2:0] xfer_sum  = {1'b0, xfer_pend_reg} + xfer_add - (xfer_done ? 3'h1 : 3'h0);
  wire        mv_take   = mv_run_reg && (mv_cnt_reg == 6'(fbac_pkg::MV_DELAY_CYC - 1));
  assign xfer_wr = xfer_wr_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      xfer_pend_reg <= 2'h0;
      xfer_wr_reg   <= 1'b0;
      mv_cnt_reg    <= 6'h00;
      mv_run_reg    <= 1'b0;
    end else begin
      xfer_pend_reg <= (xfer_sum > 3'(fbac_pkg::MAX_XFER)) ? 2'(fbac_pkg::MAX_XFER) : xfer_sum[1:0];
      if (ref_blk_start) begin
        xfer_wr_reg <= 1'b1;
      end else if (xfer_done) begin
        xfer_wr_reg <= 1'b0;
      end
      if (ref_blk_end) begin
        mv_run_reg <= 1'b1;
        mv_cnt_reg <= 6'h00;
      end else if (mv_take) begin
        mv_run_reg <= 1'b0;
      end else if (mv_run_reg) begin
        mv_cnt_reg <= mv_cnt_reg + 6'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // random port scheduler
  logic [5:0] idx_reg;
  logic [2:0] split_reg;
  logic       in_pred_reg;
  logic [6:0] fifo_cnt_reg;
  wire        fifo_full  = (fifo_cnt_reg == 7'(fbac_pkg::FIFO_DEPTH));
  wire        cas_end    = (state_reg == fbac_pkg::ST_FAST) && rcyc_page && !fifo_full;
  wire        blk_last   = (idx_reg == fbac_pkg::BLK_LAST);
  wire        page_cross = (ram_addr_reg[8:0] == fbac_pkg::ROW_LAST_COL);
  wire  [7:0] rd_sel     = field_sel_reg ? odd_rdata : even_rdata;
  wire        stay_cnt   = (state_reg == fbac_pkg::ST_FAST) && rcyc_page && fifo_full;
  assign ras_n     = !((state_reg == fbac_pkg::ST_PAGE) || (state_reg == fbac_pkg::ST_FAST));
  assign cas_n     = !(state_reg == fbac_pkg::ST_FAST);
  assign xfer_n    = !(state_reg == fbac_pkg::ST_XFER);
  assign refresh_n = !(state_reg == fbac_pkg::ST_REFRESH);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fbac_pkg::ST_IDLE: begin
        if (xfer_pend_reg != 2'h0) begin
          state_next = fbac_pkg::ST_XWAIT;
        end else if (pred_pend_reg) begin
          state_next = fbac_pkg::ST_PAGE;
        end
      end
      fbac_pkg::ST_PAGE: begin
        if (rcyc_rand) begin
          state_next = fbac_pkg::ST_FAST;
        end
      end
      fbac_pkg::ST_FAST: begin
        if (cas_end) begin
          if (blk_last) begin
            state_next = fbac_pkg::ST_REFRESH;
          end else if (xfer_pend_reg != 2'h0) begin
            state_next = fbac_pkg::ST_XWAIT;
          end else if (page_cross) begin
            state_next = fbac_pkg::ST_PAGE;
          end
        end
      end
      fbac_pkg::ST_XWAIT: begin
        if (rcyc_rand) begin
          state_next = fbac_pkg::ST_XFER;
        end
      end
      fbac_pkg::ST_XFER: begin
        if (rcyc_rand) begin
          state_next = in_pred_reg ? fbac_pkg::ST_PAGE : fbac_pkg::ST_IDLE;
        end
      end
      fbac_pkg::ST_REFRESH: begin
        if (rcyc_rand) begin
          state_next = fbac_pkg::ST_IDLE;
        end
      end
      default: state_next = fbac_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg        <= fbac_pkg::ST_IDLE;
      rcyc_reg         <= 5'h00;
      idx_reg          <= 6'h00;
      split_reg        <= 3'h0;
      in_pred_reg      <= 1'b0;
      pred_pend_reg    <= 1'b0;
      ram_addr_reg     <= 18'h00000;
      field_sel_reg    <= 1'b0;
      refresh_row_reg  <= 9'h000;
      blk_sync_out_reg <= 1'b0;
    end else begin
      state_reg        <= state_next;
      rcyc_reg         <= (state_next != state_reg || cas_end) ? 5'h00 : (stay_cnt ? rcyc_reg : rcyc_reg + 5'h01);
      blk_sync_out_reg <= cas_end && (idx_reg == 6'h00);
      if (mv_take) begin
        pred_pend_reg <= 1'b1;
        ram_addr_reg  <= mv_addr;
        split_reg     <= mv_rows;
        field_sel_reg <= (mv_rows == 3'h0);
        idx_reg       <= 6'h00;
      end else if (cas_end) begin
        idx_reg       <= idx_reg + 6'h01;
        ram_addr_reg  <= ram_addr_reg + 18'h00001;
        field_sel_reg <= ((idx_reg[2:0] + 3'h1) >= split_reg) && (split_reg != 3'h0 || 1'b1) ? 
                         ((idx_reg[2:0] + 3'h1) >= split_reg) : 1'b0;
      end
      if (state_reg == fbac_pkg::ST_IDLE && state_next == fbac_pkg::ST_PAGE) begin
        pred_pend_reg <= mv_take;
        in_pred_reg   <= 1'b1;
      end else if (state_next == fbac_pkg::ST_REFRESH && state_reg == fbac_pkg::ST_FAST) begin
        in_pred_reg   <= 1'b0;
      end
      if (state_reg == fbac_pkg::ST_REFRESH && rcyc_rand) begin
        refresh_row_reg <= refresh_row_reg + 9'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rate adaptation fifo toward the coder
  logic [7:0] fifo_mem [0:fbac_pkg::FIFO_DEPTH-1];
  logic [5:0] wr_ptr_reg;
  logic [5:0] rd_ptr_reg;
  wire        fifo_pop = pred_valid && pred_ready;
  assign pred_valid = (fifo_cnt_reg != 7'h00);
  assign pred_data  = fifo_mem[rd_ptr_reg];

  always_ff @(posedge clk_sys) begin
    if (cas_end) begin
      fifo_mem[wr_ptr_reg] <= rd_sel;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_ptr_reg   <= 6'h00;
      rd_ptr_reg   <= 6'h00;
      fifo_cnt_reg <= 7'h00;
    end else begin
      wr_ptr_reg   <= cas_end ? wr_ptr_reg + 6'h01 : wr_ptr_reg;
      rd_ptr_reg   <= fifo_pop ? rd_ptr_reg + 6'h01 : rd_ptr_reg;
      fifo_cnt_reg <= fifo_cnt_reg + (cas_end ? 7'h01 : 7'h00) - (fifo_pop ? 7'h01 : 7'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_mux_route;
    @(posedge clk_sys) disable iff (sys_rst)
    (ser_step && !ref_blk_start) |=> (sw_mid_reg == ($past(mux_swap_reg) ? $past(even_sdata) : $past(odd_sdata)));
  endproperty
  a_mux_route: assert property (p_mux_route) else $error("middle band routing wrong");

  property p_mux_swap;
    @(posedge clk_sys) disable iff (sys_rst)
    line_start |=> (mux_swap_reg != $past(mux_swap_reg));
  endproperty
  a_mux_swap: assert property (p_mux_swap) else $error("band routing did not swap");

  property p_upper;
    @(posedge clk_sys) disable iff (sys_rst)
    ser_step |=> (sw_up_reg == $past(dly_rdata)) && (dly_wdata_reg == sw_mid_reg);
  endproperty
  a_upper: assert property (p_upper) else $error("upper band not from delay line");

  property p_sw_even;
    @(posedge clk_sys) disable iff (sys_rst)
    ref_blk_start |=> (ser_rd_even_reg == $past(ref_addr) + fbac_pkg::SW_COL_OFS);
  endproperty
  a_sw_even: assert property (p_sw_even) else $error("even search start wrong");

  property p_sw_odd;
    @(posedge clk_sys) disable iff (sys_rst)
    ref_blk_start |=> (ser_rd_odd_reg - ser_rd_even_reg == ($past(band_low) ? fbac_pkg::LINE_BLK_OFS : 18'h00000));
  endproperty
  a_sw_odd: assert property (p_sw_odd) else $error("odd search start wrong");

  property p_ser_inc;
    @(posedge clk_sys) disable iff (sys_rst)
    (ser_step && !ref_blk_start) |=> (ser_rd_even_reg == $past(ser_rd_even_reg) + 18'h00001);
  endproperty
  a_ser_inc: assert property (p_ser_inc) else $error("serial address not incremented");

  property p_mv_time;
    @(posedge clk_sys) disable iff (sys_rst)
    mv_take |-> $past(ref_blk_end, fbac_pkg::MV_DELAY_CYC);
  endproperty
  a_mv_time: assert property (p_mv_time) else $error("vector taken at wrong cycle");

  property p_xfer;
    @(posedge clk_sys) disable iff (sys_rst)
    $fell(xfer_n) |-> ($past(state_reg) == fbac_pkg::ST_XWAIT) ##1 !xfer_n[*8];
  endproperty
  a_xfer: assert property (p_xfer) else $error("transfer without wait cycle");

  property p_refresh;
    @(posedge clk_sys) disable iff (sys_rst)
    (cas_end && blk_last) |=> !refresh_n;
  endproperty
  a_refresh: assert property (p_refresh) else $error("no refresh after block");

  property p_fifo;
    @(posedge clk_sys) disable iff (sys_rst)
    (fifo_full && !fifo_pop) |=> fifo_full && (wr_ptr_reg == $past(wr_ptr_reg));
  endproperty
  a_fifo: assert property (p_fifo) else $error("fifo overrun");

endmodule // fbac_ctrl

// [dv/fbac_vram_model.sv]
// data model of the two video ram fields and the delay line sram
`timescale 1ns/1ps
module fbac_vram_model (
  // clock
  input  wire logic        clk_sys,
  // addresses and strobes from the controller
  input  wire logic [17:0] ser_rd_even_reg,
  input  wire logic [17:0] ser_rd_odd_reg,
  input  wire logic [17:0] ram_addr_reg,
  input  wire logic        cas_n,
  input  wire logic [12:0] dly_addr_reg,
  // data back to the controller
  output logic      [7:0]  even_sdata,
  output logic      [7:0]  odd_sdata,
  output logic      [7:0]  even_rdata,
  output logic      [7:0]  odd_rdata,
  output logic      [7:0]  dly_rdata
);
  logic [7:0] even_last;
  logic [7:0] odd_last;

  ////////////////////////////////////////////////////////////////////////
  // top bit marks the field, low bits follow the address; delay line data is the inverted address
  assign even_sdata = {1'b0, ser_rd_even_reg[6:0]};
  assign odd_sdata  = {1'b1, ser_rd_odd_reg[6:0]};
  assign dly_rdata  = ~dly_addr_reg[7:0];
  // random port released outside cas: inverse of last value
  assign even_rdata = cas_n ? ~even_last : {1'b0, ram_addr_reg[6:0]};
  assign odd_rdata  = cas_n ? ~odd_last : {1'b1, ram_addr_reg[6:0]};

  always_ff @(posedge clk_sys) begin
    if (!cas_n) begin
      even_last <= {1'b0, ram_addr_reg[6:0]};
      odd_last  <= {1'b1, ram_addr_reg[6:0]};
    end
  end
endmodule // fbac_vram_model

// [dv/fbac_ctrl_tb.sv]
// self-checking bench for the frame buffer address controller
`timescale 1ns/1ps
module fbac_ctrl_tb;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        ref_blk_start = 1'b0;
  logic        ref_blk_end = 1'b0;
  logic        line_start = 1'b0;
  logic [17:0] ref_addr = 18'h00000;
  logic        band_low = 1'b0;
  logic [17:0] mv_addr = 18'h02000;
  logic [2:0]  mv_rows = 3'h4;
  logic        pred_ready = 1'b0;
  logic [7:0]  even_sdata, odd_sdata, even_rdata, odd_rdata, dly_rdata, dly_wdata_reg;
  logic [7:0]  sw_mid_reg, sw_low_reg, sw_up_reg, pred_data;
  logic [12:0] dly_addr_reg;
  logic [17:0] ser_rd_even_reg, ser_rd_odd_reg, ser_wr_reg, ram_addr_reg;
  logic [8:0]  refresh_row_reg;
  logic        dly_we, mux_swap_reg, ser_clk, ras_n, cas_n, xfer_n, xfer_wr, refresh_n;
  logic        field_sel_reg, pred_valid, blk_sync_out_reg, ras_q;
  int          fails = 0;
  int          checks_done = 0;
  int          ras_falls, ref_low, xfer_low, pops, syncs;

  always #5 clk_sys = ~clk_sys;

  fbac_ctrl u_fbac_ctrl (.clk_sys, .sys_rst, .ref_blk_start, .ref_blk_end, .line_start, .ref_addr, .band_low,
    .mv_addr, .mv_rows, .even_sdata, .odd_sdata, .even_rdata, .odd_rdata, .dly_rdata, .dly_addr_reg,
    .dly_wdata_reg, .dly_we, .sw_mid_reg, .sw_low_reg, .sw_up_reg, .mux_swap_reg, .ser_clk, .ser_rd_even_reg,
    .ser_rd_odd_reg, .ser_wr_reg, .ram_addr_reg, .ras_n, .cas_n, .xfer_n, .xfer_wr, .refresh_n,
    .refresh_row_reg, .field_sel_reg, .pred_ready, .pred_data, .pred_valid, .blk_sync_out_reg);

  fbac_vram_model u_fbac_vram_model (.clk_sys, .ser_rd_even_reg, .ser_rd_odd_reg, .ram_addr_reg, .cas_n,
    .dly_addr_reg, .even_sdata, .odd_sdata, .even_rdata, .odd_rdata, .dly_rdata);

  ////////////////////////////////////////////////////////////////////////
  // monitor of random port activity, fifo pops and block syncs
  always @(posedge clk_sys) begin
    ras_q <= ras_n;
    if (ras_q === 1'b1 && ras_n === 1'b0) ras_falls++;
    if (refresh_n === 1'b0) ref_low++;
    if (xfer_n === 1'b0) xfer_low++;
    if (pred_valid === 1'b1 && pred_ready) pops++;
    if (blk_sync_out_reg === 1'b1) syncs++;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic pulse(ref logic sig);
    sig = 1'b1;
    @(negedge clk_sys);
    sig = 1'b0;
  endtask

  task automatic wait_step();
    int k;
    k = 0;
    while (dly_we !== 1'b1 && k < 40) begin
      @(negedge clk_sys);
      k++;
    end
    @(negedge clk_sys);
  endtask

  task automatic t_idle(input string name);
    chk("ras_n", 18'h1, 18'(ras_n));
    chk("cas_n", 18'h1, 18'(cas_n));
    chk("xfer_n", 18'h1, 18'(xfer_n));
    chk("refresh_n", 18'h1, 18'(refresh_n));
    chk("pred_valid", 18'h0, 18'(pred_valid));
    chk("mux_swap", 18'h0, 18'(mux_swap_reg));
    chk("ser_wr", fbac_pkg::FIELD_FRAME, ser_wr_reg);
    chk("dly_addr", 18'h0167f, 18'(dly_addr_reg));
    $display("test %s done", name);
  endtask

  task automatic t_mux();
    ref_addr = 18'h01000;
    pulse(ref_blk_start);
    chk("write transfer queued", 18'h1, 18'(xfer_wr));
    wait_step();
    chk("mid band odd", 18'h1, 18'(sw_mid_reg[7]));
    chk("low band even", 18'h0, 18'(sw_low_reg[7]));
    chk("delay fed by mid", 18'h1, 18'(dly_wdata_reg[7]));
    chk("upper band", 18'h80, 18'(sw_up_reg));
    chk("serial clock", 18'h1, 18'(ser_clk));
    pulse(line_start);
    chk("swap", 18'h1, 18'(mux_swap_reg));
    wait_step();
    chk("mid band even", 18'h0, 18'(sw_mid_reg[7]));
    chk("low band odd", 18'h1, 18'(sw_low_reg[7]));
    chk("delay fed by mid", 18'h0, 18'(dly_wdata_reg[7]));
    chk("upper band", 18'h81, 18'(sw_up_reg));
    repeat (260) @(negedge clk_sys);
    chk("serial write", fbac_pkg::FIELD_FRAME + 18'h00040, ser_wr_reg);
    chk("serial clock idle", 18'h0, 18'(ser_clk));
    chk("write transfer done", 18'h0, 18'(xfer_wr));
    $display("test mux done");
  endtask

  task automatic t_addr();
    logic [17:0] n;
    logic [17:0] ofs;
    n = 18'h3ffc0;
    for (int b = 0; b < 2; b++) begin
      band_low = b[0];
      ref_addr = n;
      ofs      = b[0] ? fbac_pkg::LINE_BLK_OFS : 18'h00000;
      pulse(ref_blk_start);
      chk("even start", n + fbac_pkg::SW_COL_OFS, ser_rd_even_reg);
      chk("odd start", n + fbac_pkg::SW_COL_OFS + ofs, ser_rd_odd_reg);
      wait_step();
      chk("even step", n + fbac_pkg::SW_COL_OFS + 18'h00001, ser_rd_even_reg);
      chk("odd step", n + fbac_pkg::SW_COL_OFS + 18'h00001 + ofs, ser_rd_odd_reg);
      repeat (7) wait_step();
      chk("even wrap", n + fbac_pkg::SW_COL_OFS + 18'h00008, ser_rd_even_reg);
      repeat (260) @(negedge clk_sys);
    end
    $display("test addr done");
  endtask

  task automatic t_pred();
    int k;
    ras_falls = 0;
    ref_low = 0;
    xfer_low = 0;
    pops = 0;
    syncs = 0;
    pred_ready = 1'b0;
    mv_addr = 18'h02010;
    pulse(ref_blk_end);
    repeat (45) @(negedge clk_sys);
    ref_addr = 18'h001c0;
    pulse(ref_blk_start);
    k = 0;
    while (!(ref_low > 0 && refresh_n === 1'b1) && k < 4000) begin
      @(negedge clk_sys);
      k++;
    end
    chk("refresh width", 18'(fbac_pkg::RAND_CYC), 18'(ref_low));
    chk("refresh row", 18'h1, 18'(refresh_row_reg));
    chk("transfer width", 18'h0, 18'(xfer_low % fbac_pkg::RAND_CYC));
    chk("transfers made", 18'(fbac_pkg::MAX_XFER * fbac_pkg::RAND_CYC), 18'(xfer_low));
    chk("page selections", 18'(1 + fbac_pkg::MAX_XFER), 18'(ras_falls));
    chk("first sample", {11'h000, 7'h10}, {11'h000, pred_data[6:0]});
    chk("first field", 18'h0, 18'(pred_data[7]));
    pred_ready = 1'b1;
    k = 0;
    while (pred_valid !== 1'b0 && k < 200) begin
      chk("sample", {10'h000, (k[2:0] >= 3'h4), 7'(k + 16)}, {10'h000, pred_data});
      @(negedge clk_sys);
      k++;
    end
    pred_ready = 1'b0;
    chk("samples", 18'h40, 18'(pops));
    chk("block sync", 18'h1, 18'(syncs));
    chk("random address", 18'h02050, ram_addr_reg);
    $display("test pred done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge clk_sys);
    sys_rst = 1'b0;
    @(negedge clk_sys);
    t_idle("reset");
    t_mux();
    t_addr();
    t_pred();
    pulse(ref_blk_start);
    pulse(ref_blk_end);
    repeat (80) @(negedge clk_sys);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_idle("second reset");
    results();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    results();
  end
endmodule // fbac_ctrl_tb
